// ==== obm_bank_map_regs.sv ====
// Purpose: control register group with osd bank mapping and preamp levels
// Assumes: serial port front end delivers decoded byte writes and reads
// Notes: direct addressing only sees 256 codes of 512; extension bit is external
`default_nettype none
module obm_bank_map_regs
	import obm_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	input  wire logic [15:0] regAddr,
	input  wire logic [7:0]  regWriteData,
	output logic [7:0]       regReadData,
	output logic             regReadValid,
	input  wire logic [7:0]  charCode,
	output logic [8:0]       romAddr,
	output logic             fourColour,
	output logic [3:0]       verticalFadeStep,
	output logic [3:0]       horizontalFadeStep,
	output logic [6:0]       blueGainValue,
	output logic [6:0]       greenGainValue,
	output logic [6:0]       redGainValue,
	output logic [6:0]       contrastGainValue,
	output logic [7:0]       dac1LevelValue,
	output logic [7:0]       dac2LevelValue,
	output logic [7:0]       dac3LevelValue,
	output logic [7:0]       dac4LevelValue,
	output logic             dacHalfRange,
	output logic             dac4Mix,
	output logic             bankLookupDisable
);
	localparam int NREG = 13;
	localparam logic [15:0] ADDRS [NREG] = '{BANK_LOWER_ADDR, BANK_UPPER_ADDR,
		FADE_ADDR, BLUE_GAIN_ADDR, GREEN_GAIN_ADDR, RED_GAIN_ADDR, CONTRAST_ADDR,
		DAC1_ADDR, DAC2_ADDR, DAC3_ADDR, DAC4_ADDR, DAC_OPT_ADDR, GLOBAL_ADDR};
	// gain and contrast masks drop bit 7 in case host ignores the reserved bit
	localparam logic [7:0] MASKS [NREG] = '{BANK_MASK, BANK_MASK, FULL_MASK,
		GAIN_MASK, GAIN_MASK, GAIN_MASK, GAIN_MASK, FULL_MASK, FULL_MASK,
		FULL_MASK, FULL_MASK, GAIN_MASK, GLOB_MASK};

	logic [7:0] regVal [NREG];
	logic [7:0] next_regReadData;
	logic       next_regReadValid;

	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++) begin : g_reg
			obm_byte_reg #(.MASK(MASKS[gi])) u_reg (
				.core_clk  (core_clk),
				.reset_n   (reset_n),
				.writeEn   (regWrite && (regAddr == ADDRS[gi])),
				.writeData (regWriteData),
				.value     (regVal[gi])
			);
		end
	endgenerate

	always_comb begin
		next_regReadData  = READ_ZERO;
		next_regReadValid = regRead;
		for (int i = 0; i < NREG; i++) begin
			if (regAddr == ADDRS[i]) begin
				next_regReadData = regVal[i];
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			regReadData  <= READ_ZERO;
			regReadValid <= 1'b0;
		end else begin
			regReadData  <= next_regReadData;
			regReadValid <= next_regReadValid;
		end
	end

	assign verticalFadeStep   = regVal[2][FADE_V_LSB +: 4];
	assign horizontalFadeStep = regVal[2][FADE_H_LSB +: 4];
	assign blueGainValue      = regVal[3][GAIN_W-1:0];
	assign greenGainValue     = regVal[4][GAIN_W-1:0];
	assign redGainValue       = regVal[5][GAIN_W-1:0];
	assign contrastGainValue  = regVal[6][GAIN_W-1:0];
	assign dac1LevelValue     = regVal[7];
	assign dac2LevelValue     = regVal[8];
	assign dac3LevelValue     = regVal[9];
	assign dac4LevelValue     = regVal[10];
	assign dacHalfRange       = regVal[11][DAC_RANGE_BIT];
	assign dac4Mix            = regVal[11][DAC_MIX_BIT];
	assign bankLookupDisable  = regVal[12][BANK_DIS_BIT];

	obm_rom_map u_map (
		.charCode          (charCode),
		.bankLower         (regVal[0]),
		.bankUpper         (regVal[1]),
		.bankLookupDisable (bankLookupDisable),
		.romAddr           (romAddr),
		.fourColour        (fourColour)
	);

	// a read is taken on one edge and answered on the next
	sequence s_read_taken;
		regRead;
	endsequence
	sequence s_read_answer;
		regReadValid;
	endsequence

	a_upper_field: assert property (@(posedge core_clk) disable iff (!reset_n)
		(!bankLookupDisable && charCode[7:6] == 2'b10)
		|-> romAddr == {regVal[1][2:0], charCode[5:0]})
		else $error("field two bank wrong");
	a_top_field: assert property (@(posedge core_clk) disable iff (!reset_n)
		(!bankLookupDisable && charCode[7:6] == 2'b11)
		|-> romAddr[8:6] == regVal[1][6:4])
		else $error("field three bank wrong");
	a_lower_fields: assert property (@(posedge core_clk) disable iff (!reset_n)
		(!bankLookupDisable && !charCode[7])
		|-> romAddr[8:6] == (charCode[6] ? regVal[0][6:4] : regVal[0][2:0]))
		else $error("lower field bank wrong");
	a_low_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
		romAddr[5:0] == charCode[5:0])
		else $error("low code bits not passed");
	a_direct_mode: assert property (@(posedge core_clk) disable iff (!reset_n)
		bankLookupDisable |-> romAddr == {1'b0, charCode})
		else $error("direct address wrong");
	a_colour_type: assert property (@(posedge core_clk) disable iff (!reset_n)
		fourColour == (romAddr[7:6] == 2'b11))
		else $error("colour type wrong");
	a_gain_write: assert property (@(posedge core_clk) disable iff (!reset_n)
		regWrite && regAddr == BLUE_GAIN_ADDR
		|=> blueGainValue == $past(regWriteData[6:0]))
		else $error("blue gain not stored");
	a_green_write: assert property (@(posedge core_clk) disable iff (!reset_n)
		regWrite && regAddr == GREEN_GAIN_ADDR
		|=> greenGainValue == $past(regWriteData[6:0]))
		else $error("green gain not stored");
	a_red_write: assert property (@(posedge core_clk) disable iff (!reset_n)
		regWrite && regAddr == RED_GAIN_ADDR
		|=> redGainValue == $past(regWriteData[6:0]))
		else $error("red gain not stored");
	a_contrast_write: assert property (@(posedge core_clk) disable iff (!reset_n)
		regWrite && regAddr == CONTRAST_ADDR
		|=> contrastGainValue == $past(regWriteData[6:0]) && !regVal[6][7])
		else $error("contrast not stored");
	a_fade_write: assert property (@(posedge core_clk) disable iff (!reset_n)
		regWrite && regAddr == FADE_ADDR
		|=> {verticalFadeStep, horizontalFadeStep} == $past(regWriteData))
		else $error("fade not stored");
	a_dac_one_write: assert property (@(posedge core_clk) disable iff (!reset_n)
		regWrite && regAddr == DAC1_ADDR
		|=> dac1LevelValue == $past(regWriteData))
		else $error("dac 1 level not stored");
	a_dac_two_write: assert property (@(posedge core_clk) disable iff (!reset_n)
		regWrite && regAddr == DAC2_ADDR
		|=> dac2LevelValue == $past(regWriteData))
		else $error("dac 2 level not stored");
	a_dac_three_write: assert property (@(posedge core_clk) disable iff (!reset_n)
		regWrite && regAddr == DAC3_ADDR
		|=> dac3LevelValue == $past(regWriteData))
		else $error("dac 3 level not stored");
	a_dac_four_write: assert property (@(posedge core_clk) disable iff (!reset_n)
		regWrite && regAddr == DAC4_ADDR
		|=> dac4LevelValue == $past(regWriteData))
		else $error("dac 4 level not stored");
	a_option_write: assert property (@(posedge core_clk) disable iff (!reset_n)
		regWrite && regAddr == DAC_OPT_ADDR
		|=> {dac4Mix, dacHalfRange}
			== $past({regWriteData[DAC_MIX_BIT], regWriteData[DAC_RANGE_BIT]}))
		else $error("dac options not stored");
	a_lookup_write: assert property (@(posedge core_clk) disable iff (!reset_n)
		regWrite && regAddr == GLOBAL_ADDR
		|=> bankLookupDisable == $past(regWriteData[BANK_DIS_BIT]))
		else $error("lookup disable not stored");
	// a same-edge write must not leak into the read answer
	a_readback: assert property (@(posedge core_clk) disable iff (!reset_n)
		regRead && regAddr == DAC4_ADDR
		|=> regReadValid && regReadData == $past(dac4LevelValue))
		else $error("readback wrong");
	a_read_answer: assert property (@(posedge core_clk) disable iff (!reset_n)
		s_read_taken |=> s_read_answer)
		else $error("read not answered");
	a_valid_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
		!regRead |=> !regReadValid)
		else $error("read valid without read");
	a_steps_stable: assert property (@(posedge core_clk) disable iff (!reset_n)
		!regWrite |=> $stable({verticalFadeStep, horizontalFadeStep, blueGainValue}))
		else $error("levels moved without write");
endmodule
`default_nettype wire

// ==== obm_pkg.sv ====
// Purpose: constants for the osd bank map and preamp control register group
// Assumes: byte-wide register port, 16-bit register addresses
// Notes: reset values are a design choice; analog consumers sit outside
`default_nettype none
package obm_pkg;
	localparam int          ADDR_W        = 16;
	localparam int          DATA_W        = 8;
	localparam int          ROM_ADDR_W    = 9;
	localparam int          BANK_W        = 3;
	localparam int          NUM_REGS      = 10;
	localparam int          REG_IDX_W     = 4;
	localparam logic [15:0] BANK_LOWER_ADDR = 16'h8427;
	localparam logic [15:0] BANK_UPPER_ADDR = 16'h8428;
	localparam logic [15:0] FADE_ADDR       = 16'h8429;
	localparam logic [15:0] BLUE_GAIN_ADDR  = 16'h8430;
	localparam logic [15:0] GREEN_GAIN_ADDR = 16'h8431;
	localparam logic [15:0] RED_GAIN_ADDR   = 16'h8432;
	localparam logic [15:0] CONTRAST_ADDR   = 16'h8433;
	localparam logic [15:0] DAC1_ADDR       = 16'h8434;
	localparam logic [15:0] DAC2_ADDR       = 16'h8435;
	localparam logic [15:0] DAC3_ADDR       = 16'h8436;
	localparam logic [15:0] DAC4_ADDR       = 16'h8437;
	localparam logic [15:0] DAC_OPT_ADDR    = 16'h8438;
	localparam logic [15:0] GLOBAL_ADDR     = 16'h8439;
	// field positions
	localparam int FIELD_LO_LSB   = 0;
	localparam int FIELD_HI_LSB   = 4;
	localparam int FADE_V_LSB     = 4;
	localparam int FADE_H_LSB     = 0;
	localparam int GAIN_W         = 7;
	localparam int DAC_RANGE_BIT  = 5;
	localparam int DAC_MIX_BIT    = 6;
	localparam int BANK_DIS_BIT   = 2;
	localparam int CODE_LOW_W     = 6;
	// reserved-bit masks: reserved bits read as zero
	localparam logic [7:0] BANK_MASK = 8'h77;
	localparam logic [7:0] GAIN_MASK = 8'h7f;
	localparam logic [7:0] FULL_MASK = 8'hff;
	localparam logic [7:0] GLOB_MASK = 8'h07;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	// banks holding four-colour characters
	localparam logic [2:0] FOUR_COLOUR_LO = 3'h3;
	localparam logic [2:0] FOUR_COLOUR_HI = 3'h7;
endpackage
`default_nettype wire

// ==== obm_byte_reg.sv ====
// Purpose: one masked control byte with write strobe
// Assumes: same clock as register port
// Notes: reserved bits are masked at write so they read zero
`default_nettype none
module obm_byte_reg
	import obm_pkg::*;
#(
	parameter logic [7:0] MASK = 8'hff
) (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       writeEn,
	input  wire logic [7:0] writeData,
	output var  logic [7:0] value
);
	logic [7:0] next_value;

	always_comb begin
		next_value = value;
		if (writeEn) begin
			next_value = writeData & MASK;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			value <= REG_RESET;
		end else begin
			value <= next_value;
		end
	end

	a_hold_value: assert property (@(posedge core_clk) disable iff (!reset_n)
		!writeEn |=> value == $past(value))
		else $error("register changed without write");
endmodule
`default_nettype wire

// ==== obm_rom_map.sv ====
// Purpose: forms nine-bit character rom address from page ram code
// Assumes: bank fields are held stable by the register group
// Notes: pure logic so the fetch pipeline gains no stage
`default_nettype none
module obm_rom_map
	import obm_pkg::*;
(
	input  wire logic [7:0] charCode,
	input  wire logic [7:0] bankLower,
	input  wire logic [7:0] bankUpper,
	input  wire logic       bankLookupDisable,
	output logic [8:0]      romAddr,
	output logic            fourColour
);
	logic [2:0] bankField [4];
	logic [2:0] chosenBank;

	assign bankField[0] = bankLower[FIELD_LO_LSB +: BANK_W];
	assign bankField[1] = bankLower[FIELD_HI_LSB +: BANK_W];
	assign bankField[2] = bankUpper[FIELD_LO_LSB +: BANK_W];
	assign bankField[3] = bankUpper[FIELD_HI_LSB +: BANK_W];

	always_comb begin
		// top two code bits index the four fields, so only four banks are live
		chosenBank = bankField[charCode[7:6]];
		if (bankLookupDisable) begin
			romAddr    = {1'b0, charCode};
			chosenBank = romAddr[8:6];
		end else begin
			romAddr = {chosenBank, charCode[CODE_LOW_W-1:0]};
		end
		fourColour = (chosenBank == FOUR_COLOUR_LO) || (chosenBank == FOUR_COLOUR_HI);
	end
endmodule
`default_nettype wire

// ==== obm_host_model.sv ====
// Purpose: host side model issuing byte register writes and reads
// Assumes: strobes change just after the core_clk rising edge
// Notes: legal writes clear reserved bits of bank, gain and contrast registers only; raw writes exist for refusal tests
`default_nettype none
module obm_host_model
	import obm_pkg::*;
(
	input  wire logic        core_clk,
	output var  logic        regWrite,
	output var  logic        regRead,
	output var  logic [15:0] regAddr,
	output var  logic [7:0]  regWriteData,
	input  wire logic [7:0]  regReadData,
	input  wire logic        regReadValid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 16'h0000;
		regWriteData = 8'h00;
	end
	// reserved positions a careful host leaves at zero
	function automatic logic [7:0] resvMask(input logic [15:0] a);
		if (a == BANK_LOWER_ADDR || a == BANK_UPPER_ADDR) return BANK_MASK;
		if (a >= BLUE_GAIN_ADDR && a <= CONTRAST_ADDR) return GAIN_MASK;
		return FULL_MASK;
	endfunction
	task automatic wrRaw(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWriteData <= d;
		@(posedge core_clk);
		regWrite <= 1'b0;
		regWriteData <= ~d;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		wrRaw(a, d & resvMask(a));
	endtask
	// data and valid stand for one cycle after the taking edge
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
		@(posedge core_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1;
		d = regReadData;
		v = regReadValid;
	endtask
endmodule
`default_nettype wire

// ==== obm_bank_map_regs_test.sv ====
// Purpose: self-checking bench for the bank map and preamp register group
// Assumes: host model drives the register port
// Notes: expected values come from the tables below, not from the design
`default_nettype none
module obm_bank_map_regs_test
	import obm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] ADR [13] = '{16'h8427, 16'h8428, 16'h8429, 16'h8430,
		16'h8431, 16'h8432, 16'h8433, 16'h8434, 16'h8435, 16'h8436, 16'h8437,
		16'h8438, 16'h8439};
	localparam logic [7:0] MSK [13] = '{8'h77, 8'h77, 8'hff, 8'h7f, 8'h7f, 8'h7f,
		8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h07};
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] charCode = 8'h00;
	logic regWrite, regRead, regReadValid, fourColour, dacHalfRange, dac4Mix, bankDis;
	logic [15:0] regAddr;
	logic [7:0] regWriteData, regReadData, d1, d2, d3, d4, rdat;
	logic [8:0] romAddr;
	logic [3:0] vStep, hStep;
	logic [6:0] bGain, gGain, rGain, cGain;
	logic rval;
	logic [7:0] v [13];
	logic [2:0] f [4];
	int fail_count = 0;
	int tests_run = 0;
	always #5 core_clk = ~core_clk;
	obm_host_model u_host (.core_clk(core_clk), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
		.regReadValid(regReadValid));
	obm_bank_map_regs u_dut (.core_clk(core_clk), .reset_n(reset_n), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
		.regReadData(regReadData), .regReadValid(regReadValid), .charCode(charCode),
		.romAddr(romAddr), .fourColour(fourColour), .verticalFadeStep(vStep),
		.horizontalFadeStep(hStep), .blueGainValue(bGain), .greenGainValue(gGain),
		.redGainValue(rGain), .contrastGainValue(cGain), .dac1LevelValue(d1),
		.dac2LevelValue(d2), .dac3LevelValue(d3), .dac4LevelValue(d4),
		.dacHalfRange(dacHalfRange), .dac4Mix(dac4Mix), .bankLookupDisable(bankDis));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			$display("[ERR] %0t %s", $time, m);
			fail_count++;
		end
	endtask
	task automatic rdChk(input logic [15:0] a, input logic [7:0] exp);
		u_host.rd(a, rdat, rval);
		chk({15'h0, rval}, 16'h1, "read valid missing");
		chk({8'h0, rdat}, {8'h0, exp}, "read data");
		@(posedge core_clk);
		#1;
		chk({15'h0, regReadValid}, 16'h0, "read valid stuck");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		finish_test();
	end
	initial begin
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 13; i++) rdChk(ADR[i], 8'h00);
		$display("test reset_values done");
		// raw writes with reserved bits set: the group must store them as zero
		for (int i = 0; i < 13; i++) v[i] = 8'ha9 ^ 8'(i * 4);
		for (int i = 0; i < 13; i++) u_host.wrRaw(ADR[i], v[i]);
		for (int i = 0; i < 13; i++) rdChk(ADR[i], v[i] & MSK[i]);
		chk({8'h0, vStep, hStep}, {8'h0, v[2]}, "fade steps");
		chk({2'h0, bGain, gGain}, {2'h0, v[3][6:0], v[4][6:0]}, "blue green");
		chk({2'h0, rGain, cGain}, {2'h0, v[5][6:0], v[6][6:0]}, "red contrast");
		chk({d1, d2}, {v[7], v[8]}, "dac 1 2 levels");
		chk({d3, d4}, {v[9], v[10]}, "dac 3 4 levels");
		chk(16'({dacHalfRange, dac4Mix}), 16'({v[11][5], v[11][6]}), "dac options");
		$display("test register_map done");
		u_host.wr(GLOBAL_ADDR, 8'h00);
		for (int b = 0; b < 8; b++) begin
			for (int t = 0; t < 4; t++) f[t] = 3'(b + t);
			u_host.wr(BANK_LOWER_ADDR, {1'b0, f[1], 1'b0, f[0]});
			u_host.wr(BANK_UPPER_ADDR, {1'b0, f[3], 1'b0, f[2]});
			for (int t = 0; t < 4; t++) begin
				@(posedge core_clk);
				charCode <= {2'(t), 6'(b * 9 + t * 21)};
				#1;
				chk(16'(romAddr[8:6]), 16'(f[t]), "bank");
				chk(16'(romAddr[5:0]), 16'(charCode[5:0]), "low bits");
				chk(16'(fourColour), 16'(f[t] == 3'h3 || f[t] == 3'h7), "colour");
			end
		end
		$display("test bank_lookup done");
		u_host.wr(GLOBAL_ADDR, 8'h04);
		#1;
		chk({15'h0, bankDis}, 16'h1, "lookup disable");
		for (int c = 0; c < 256; c += 51) begin
			@(posedge core_clk);
			charCode <= 8'(c);
			#1;
			chk({7'h0, romAddr}, {8'h0, 8'(c)}, "direct address");
		end
		$display("test direct_mode done");
		u_host.wr(DAC_OPT_ADDR, 8'h60);
		#1;
		chk(16'({dacHalfRange, dac4Mix}), 16'h3, "dac options set");
		$display("test dac_options done");
		u_host.wrRaw(16'h842a, 8'hff);
		rdChk(16'h842a, READ_ZERO);
		rdChk(FADE_ADDR, v[2]);
		$display("test unmapped done");
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		rdChk(DAC_OPT_ADDR, 8'h00);
		chk({15'h0, bankDis}, 16'h0, "lookup disable after reset");
		$display("test second_reset done");
		finish_test();
	end
endmodule
`default_nettype wire
